/* rtl/slot_order_pkg.sv */
// Purpose: shared constants for the wake-up slot order map
// Assumes: 16-bit register file on a plain strobe port
// Notes:   offsets are byte addresses, one register per word
`default_nettype none
package slot_order_pkg;
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 16;
  localparam int          SEL_W             = 2;
  localparam int          SLOT_W            = 3;
  localparam int          NUM_SLOTS         = 8;
  localparam int          CNT_W             = 20;
  localparam logic [11:0] TIMER_CTRL_OFFSET = 12'h800;
  localparam logic [11:0] SLOT_ORDER_OFFSET = 12'h804;
  localparam logic [11:0] SLOT_COUNT_OFFSET = 12'h808;
  localparam logic [11:0] TIMER_STAT_OFFSET = 12'h80C;
  localparam logic [15:0] SLOT_ORDER_RESET  = 16'h0000;
  localparam logic [15:0] TIMER_CTRL_RESET  = 16'h0000;
  localparam logic [19:0] SLOT_COUNT_RESET  = 20'h00010;
  localparam int          CTRL_EN_BIT       = 0;
  localparam int          CTRL_FINAL_LSB    = 1;
  localparam int          CTRL_MASK_BIT     = 6;
  localparam int          SLOT_E_LSB        = 8;
  localparam int          SLOT_F_LSB        = 10;
  localparam int          SLOT_G_LSB        = 12;
  localparam int          SLOT_H_LSB        = 14;
  localparam logic [2:0]  SLOT_A            = 3'h0;
  localparam logic [1:0]  SEQ_ZERO          = 2'h0;
  localparam logic [1:0]  SEQ_ONE           = 2'h1;
  localparam logic [1:0]  SEQ_TWO           = 2'h2;
  localparam logic [1:0]  SEQ_THREE         = 2'h3;
  localparam logic [3:0]  ONEHOT_ZERO       = 4'h1;
  localparam logic [3:0]  ONEHOT_ONE        = 4'h2;
  localparam logic [3:0]  ONEHOT_TWO        = 4'h4;
  localparam logic [3:0]  ONEHOT_THREE      = 4'h8;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_RUN  = 2'h2
  } timer_state_t;
endpackage
`default_nettype wire

/* rtl/slot_sequence_decode.sv */
// Purpose: decode a 2-bit slot field to a one-hot stored-sequence request
// Assumes: field comes from the slot order register for slots E to H, from the slot number for A to D
// Notes:   purely combinational
`default_nettype none
module slot_sequence_decode (
  // field in
  input  wire logic [slot_order_pkg::SEL_W-1:0] select_i,
  // one-hot out
  output logic [3:0]                            onehot_o
);
  import slot_order_pkg::*;

  // fixed mapping of field code to sequence
  always_comb begin
    case (select_i)
      SEQ_ZERO: onehot_o = ONEHOT_ZERO;
      SEQ_ONE:  onehot_o = ONEHOT_ONE;
      SEQ_TWO:  onehot_o = ONEHOT_TWO;
      default:  onehot_o = ONEHOT_THREE;
    endcase
  end
endmodule
`default_nettype wire

/* rtl/slot_countdown.sv */
// Purpose: reloadable countdown giving an expiry pulse per slot
// Assumes: reload value held stable by the owner
// Notes:   expires one cycle after reaching one, then reloads
`default_nettype none
module slot_countdown #(
  parameter int CNT_W = 20
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // control
  input  wire logic             run_i,
  input  wire logic [CNT_W-1:0] reload_i,
  // status
  output logic                  expire_o,
  output logic [CNT_W-1:0]      count_o
);
  // count down while running, reload on expiry or when stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o  <= '0;
      expire_o <= 1'b0;
    end else if (!run_i) begin
      count_o  <= reload_i;
      expire_o <= 1'b0;
    end else if (count_o <= CNT_W'(1)) begin
      count_o  <= reload_i;
      expire_o <= 1'b1;
    end else begin
      count_o  <= count_o - CNT_W'(1);
      expire_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* rtl/wakeup_slot_order_map.sv */
// Purpose: slot-to-sequence order map for the sleep and wake-up timer
// Assumes: single clock, register port with read data one cycle later
// Notes:   slots A to D map to fixed sequences 0,1,2,3 here
// Notes on behaviour
// - 16-bit slot order register, all fields zero after reset
// - field codes 0,1,2,3 select stored sequences 0,1,2,3
// - bits 15:14 pick the sequence triggered at slot H, read/write
// - bits 13:12 pick the sequence triggered at slot G, read/write
// - bits 11:10 pick the sequence triggered at slot F, read/write
// - bits 9:8 pick the sequence triggered at slot E, same decoding
// - after the final slot triggers, the cycle restarts at slot A
`default_nettype none
module wakeup_slot_order_map #(
  parameter int CNT_W = slot_order_pkg::CNT_W
) (
  // clock and reset
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_i,
  // register port
  input  wire logic [slot_order_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [slot_order_pkg::DATA_W-1:0]    wdata_i,
  input  wire logic                                 wr_i,
  input  wire logic                                 rd_i,
  output logic      [slot_order_pkg::DATA_W-1:0]    rdata_o,
  // sequencer triggers
  output logic      [3:0]                           seq_trigger_o,
  output logic      [slot_order_pkg::SLOT_W-1:0]    slot_o
);
  import slot_order_pkg::*;

  logic [DATA_W-1:0] sequence_slot_order;
  logic [DATA_W-1:0] timer_ctrl;
  logic [CNT_W-1:0]  slot_count;
  logic [SLOT_W-1:0] slot;
  timer_state_t      state;
  logic              expire;
  logic [CNT_W-1:0]  count;
  logic [SEL_W-1:0]  cur_select;
  logic [3:0]        cur_onehot;
  logic              timer_en;
  logic              trig_mask;
  logic [SLOT_W-1:0] final_slot_select;

  assign timer_en          = timer_ctrl[CTRL_EN_BIT];
  assign trig_mask         = timer_ctrl[CTRL_MASK_BIT];
  assign final_slot_select = timer_ctrl[CTRL_FINAL_LSB +: SLOT_W];

  // field of one slot, from the order register for E to H, the slot number for A to D
  function automatic logic [SEL_W-1:0] slot_field(input logic [SLOT_W-1:0] s,
                                                  input logic [DATA_W-1:0] r);
    case (s)
      3'h4:    slot_field = r[SLOT_E_LSB +: SEL_W];
      3'h5:    slot_field = r[SLOT_F_LSB +: SEL_W];
      3'h6:    slot_field = r[SLOT_G_LSB +: SEL_W];
      3'h7:    slot_field = r[SLOT_H_LSB +: SEL_W];
      default: slot_field = s[SEL_W-1:0];
    endcase
  endfunction

  // order register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sequence_slot_order <= SLOT_ORDER_RESET;
    end else if (wr_i && addr_i == SLOT_ORDER_OFFSET) begin
      sequence_slot_order <= wdata_i;
    end
  end

  // control register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_ctrl <= TIMER_CTRL_RESET;
    end else if (wr_i && addr_i == TIMER_CTRL_OFFSET) begin
      timer_ctrl <= wdata_i;
    end
  end

  // slot period writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_count <= SLOT_COUNT_RESET;
    end else if (wr_i && addr_i == SLOT_COUNT_OFFSET) begin
      slot_count <= {{(CNT_W-DATA_W){1'b0}}, wdata_i};
    end
  end

  // read mux, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      if (addr_i == SLOT_ORDER_OFFSET) begin
        rdata_o <= sequence_slot_order;
      end else if (addr_i == TIMER_CTRL_OFFSET) begin
        rdata_o <= timer_ctrl;
      end else if (addr_i == SLOT_COUNT_OFFSET) begin
        rdata_o <= slot_count[DATA_W-1:0];
      end else if (addr_i == TIMER_STAT_OFFSET) begin
        rdata_o <= {{(DATA_W-SLOT_W-1){1'b0}}, state == ST_RUN, slot};
      end else begin
        rdata_o <= '0;
      end
    end else begin
      rdata_o <= '0;
    end
  end

  // per-slot countdown
  slot_countdown #(
    .CNT_W (CNT_W)
  ) u_countdown (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .run_i    (state == ST_RUN),
    .reload_i (slot_count),
    .expire_o (expire),
    .count_o  (count)
  );

  // field sampled at the moment of expiry
  assign cur_select = slot_field(slot, sequence_slot_order);

  slot_sequence_decode u_decode (
    .select_i (cur_select),
    .onehot_o (cur_onehot)
  );

  // timer state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (timer_en) state <= ST_RUN;
        ST_RUN:  if (!timer_en) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // slot stepping, wraps after the final slot
  always_ff @(posedge clk_i) begin
    if (rst_i || state != ST_RUN) begin
      slot <= SLOT_A;
    end else if (expire) begin
      if (slot == final_slot_select) begin
        slot <= SLOT_A;
      end else begin
        slot <= slot + SLOT_W'(1);
      end
    end
  end

  // trigger pulse registered from sampled field
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_trigger_o <= '0;
      slot_o        <= SLOT_A;
    end else if (expire && state == ST_RUN && !trig_mask) begin
      seq_trigger_o <= cur_onehot;
      slot_o        <= slot;
    end else begin
      seq_trigger_o <= '0;
    end
  end

  // checks
  sequence fire_s;
    expire && state == ST_RUN && !trig_mask && timer_en;
  endsequence

  order_reset_a: assert property (@(posedge clk_i) $past(rst_i) |-> sequence_slot_order == '0)
    else $error("order register not zero after reset");
  decode_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fire_s |=> seq_trigger_o == (4'h1 << $past(cur_select)))
    else $error("trigger not one-hot of field");
  slot_h_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fire_s and slot == 3'h7 |=> seq_trigger_o == (4'h1 << $past(sequence_slot_order[15:14])))
    else $error("slot H trigger mismatch");
  slot_g_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fire_s and slot == 3'h6 |=> seq_trigger_o == (4'h1 << $past(sequence_slot_order[13:12])))
    else $error("slot G trigger mismatch");
  slot_f_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fire_s and slot == 3'h5 |=> seq_trigger_o == (4'h1 << $past(sequence_slot_order[11:10])))
    else $error("slot F trigger mismatch");
  slot_e_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fire_s and slot == 3'h4 |=> seq_trigger_o == (4'h1 << $past(sequence_slot_order[9:8])))
    else $error("slot E trigger mismatch");
  final_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    expire && state == ST_RUN && timer_en && slot == final_slot_select |=> slot == SLOT_A)
    else $error("no wrap after final slot");
  order_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == SLOT_ORDER_OFFSET |=> sequence_slot_order == $past(wdata_i))
    else $error("order write lost");
  quiet_trig_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !expire |=> seq_trigger_o == '0)
    else $error("trigger without expiry");
endmodule
`default_nettype wire

/* verification/tb_wakeup_slot_order_map.sv */
// Purpose: self-checking bench for the wake-up slot order map
// Assumes: slot period shortened to 4 cycles through the period register
// Notes:   each run starts from a fresh reset so slot A is always first
`default_nettype none
module tb_wakeup_slot_order_map;
  timeunit 1ns;
  timeprecision 1ns;
  import slot_order_pkg::*;

  // design ports
  logic                clk_i;
  logic                rst_i;
  logic [ADDR_W-1:0]   addr_i;
  logic [DATA_W-1:0]   wdata_i;
  logic                wr_i;
  logic                rd_i;
  logic [DATA_W-1:0]   rdata_o;
  logic [3:0]          seq_trigger_o;
  logic [SLOT_W-1:0]   slot_o;
  int                  n_fail;
  int                  check_count;

  wakeup_slot_order_map #(.CNT_W(CNT_W)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .seq_trigger_o(seq_trigger_o), .slot_o(slot_o));

  // 50 ns clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // compare and count
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic bus_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic bus_rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  // short reset, then period, order and control
  task automatic start(input logic [15:0] order, input logic [15:0] ctrl);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus_wr(SLOT_COUNT_OFFSET, 16'h0004);
    bus_wr(SLOT_ORDER_OFFSET, order);
    bus_wr(TIMER_CTRL_OFFSET, ctrl);
  endtask

  // wait for the next trigger pulse, then judge slot and sequence
  task automatic next_trig(input logic [2:0] slot, input logic [1:0] code);
    int i;
    i = 0;
    do begin
      @(posedge clk_i);
      #1 i++;
    end while (seq_trigger_o === 4'h0 && i < 60);
    chk("trigger slot", 16'(slot), 16'(slot_o));
    chk("trigger sequence", 16'(4'(ONEHOT_ZERO << code)), 16'(seq_trigger_o));
  endtask

  // field pattern with a different code in each upper slot
  function automatic logic [15:0] pat(input int k);
    return {2'(k + 3), 2'(k + 2), 2'(k + 1), 2'(k), 8'h00};
  endfunction

  // reset value and an unmapped read
  task automatic test_reset_values();
    logic [15:0] d;
    bus_rd(SLOT_ORDER_OFFSET, d);
    chk("order reset", SLOT_ORDER_RESET, d);
    @(posedge clk_i);
    #1 chk("read data one cycle", 16'h0000, rdata_o);
    bus_rd(12'h810, d);
    chk("unmapped read", 16'h0000, d);
  endtask

  // every code written and read back in every upper field
  task automatic test_field_rw();
    logic [15:0] d;
    logic [15:0] p;
    for (int k = 0; k < 4; k++) begin
      p = pat(k);
      bus_wr(SLOT_ORDER_OFFSET, p);
      bus_rd(SLOT_ORDER_OFFSET, d);
      chk("order fields", {p[15:8], 8'h00}, {d[15:8], 8'h00});
    end
  endtask

  // full cycle A..H and wrap, each code in each upper slot
  task automatic test_order_run();
    logic [15:0] o;
    for (int k = 0; k < 4; k++) begin
      o = pat(k);
      start(o, 16'h000F);
      for (int s = 0; s < 9; s++) begin
        if (s % 8 < 4) next_trig(3'(s % 8), 2'(s % 8));
        else next_trig(3'(s), o[2 * s +: 2]);
      end
    end
  endtask

  // final slot E wraps straight back to A
  task automatic test_final_e();
    start(16'h0300, 16'h0009);
    for (int s = 0; s < 4; s++) next_trig(3'(s), 2'(s));
    next_trig(3'h4, 2'h3);
    next_trig(3'h0, 2'h0);
  endtask

  // masked triggers never appear
  task automatic test_mask();
    int seen;
    seen = 0;
    start(16'h0000, 16'h004F);
    repeat (40) begin
      @(posedge clk_i);
      #1 if (seq_trigger_o !== 4'h0) seen++;
    end
    chk("masked triggers", 16'h0000, 16'(seen));
  endtask

  // a write during the run applies from the next triggered slot
  task automatic test_late_write();
    start(16'h0000, 16'h000F);
    for (int s = 0; s < 4; s++) next_trig(3'(s), 2'(s));
    next_trig(3'h4, 2'h0);
    bus_wr(SLOT_ORDER_OFFSET, 16'h3000);
    next_trig(3'h5, 2'h0);
    next_trig(3'h6, 2'h3);
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    rst_i = 1'b1;
    addr_i = '0;
    wdata_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    n_fail = 0;
    check_count = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset_values();
    test_field_rw();
    test_order_run();
    test_final_e();
    test_mask();
    test_late_write();
    report_and_stop();
  end

  // hang guard, about 20000 cycles
  initial begin
    #1000000;
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
